// *** design/cfg_regs.sv ***
// reader front end configuration register bank with field decoders
`timescale 1ns/1ps
module cfg_regs
    import cfg_regs_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic enable,
    input wire logic wr_en,
    input wire logic [4:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [4:0] rd_addr,
    output logic [7:0] rd_data,
    input wire logic direct_mode,
    input wire logic ask_ook_pin,
    output logic ook_select,
    output logic analog_test_out,
    output logic clock_divider_select_high,
    output logic clock_divider_select_low,
    output clk_out_e system_clock_output,
    output mod_depth_e modulation_depth,
    output logic filter_select_low_subcarrier,
    output logic filter_select_mid_subcarrier,
    output logic filter_select_manchester_subcarrier,
    output logic high_rate_filter,
    output logic [3:0] gain_reduction_db,
    output logic auto_regulator,
    output logic external_amplifier_support,
    output logic ook_pin_mod_output,
    output logic rx_external_subcarrier,
    output logic low_io_drive,
    output logic [2:0] voltage_code
);
    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [7:0] mod_clk_q;
    logic [7:0] rx_set_q;
    logic [7:0] reg_io_q;
    logic proto_wr;
    logic [2:0] ask_sync_q;
    logic ask_level_q;

    assign proto_wr = wr_en && (wr_addr == ADDR_PROTOCOL_CTRL);

    // divider bits survive a protocol write, rest reloads
    cfg_byte_reg #(
        .RESET_VAL(MOD_CLK_RESET),
        .WR_MASK(MOD_CLK_MASK),
        .RELOAD_MASK(MOD_CLK_MASK & ~CLK_DIV_FIELD)
    ) u_mod_clk (
        .mclk(mclk),
        .reset_n(reset_n),
        .enable(enable),
        .wr_en(wr_en && (wr_addr == ADDR_MOD_CLK)),
        .wr_data(wr_data),
        .reload(proto_wr),
        .value_q(mod_clk_q)
    );

    // whole register reloads on protocol write
    cfg_byte_reg #(
        .RESET_VAL(RX_SETTING_RESET),
        .WR_MASK(RX_SETTING_MASK),
        .RELOAD_MASK(8'hff)
    ) u_rx_set (
        .mclk(mclk),
        .reset_n(reset_n),
        .enable(enable),
        .wr_en(wr_en && (wr_addr == ADDR_RX_SETTING)),
        .wr_data(wr_data),
        .reload(proto_wr),
        .value_q(rx_set_q)
    );

    // no reload mask: protocol writes leave it alone
    cfg_byte_reg #(
        .RESET_VAL(REGULATOR_RESET),
        .WR_MASK(REGULATOR_MASK),
        .RELOAD_MASK(8'h00)
    ) u_reg_io (
        .mclk(mclk),
        .reset_n(reset_n),
        .enable(enable),
        .wr_en(wr_en && (wr_addr == ADDR_REGULATOR)),
        .wr_data(wr_data),
        .reload(proto_wr),
        .value_q(reg_io_q)
    );

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    // unmapped addresses read zero; other registers live elsewhere
    always_comb begin
        case (rd_addr)
            ADDR_MOD_CLK: rd_data = mod_clk_q;
            ADDR_RX_SETTING: rd_data = rx_set_q;
            ADDR_REGULATOR: rd_data = reg_io_q;
            default: rd_data = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // external modulation select pin
    // ------------------------------------------------------------
    // pin is asynchronous: three stages, change taken when 2 and 3 agree
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ask_sync_q <= 3'h0;
            ask_level_q <= 1'b0;
        end else begin
            ask_sync_q <= {ask_sync_q[1:0], ask_ook_pin};
            if (ask_sync_q[1] == ask_sync_q[2]) begin
                ask_level_q <= ask_sync_q[2];
            end
        end
    end

    // pin wins only in direct mode, else register depth decides
    assign ook_select = (mod_clk_q[EXT_MOD_SEL_BIT] && direct_mode) ?
        ask_level_q : (mod_clk_q[MOD_DEPTH_MSB:0] == 3'(OOK_100));

    // ------------------------------------------------------------
    // modulator and clock output decode
    // ------------------------------------------------------------
    assign analog_test_out = mod_clk_q[ANALOG_OUT_BIT];
    assign clock_divider_select_high = mod_clk_q[CLK_DIV_MSB];
    assign clock_divider_select_low = mod_clk_q[CLK_DIV_LSB];
    // field codes map one to one onto the enum
    assign system_clock_output =
        clk_out_e'(mod_clk_q[CLK_DIV_MSB:CLK_DIV_LSB]);
    assign modulation_depth =
        mod_depth_e'(mod_clk_q[MOD_DEPTH_MSB:0]);

    // ------------------------------------------------------------
    // receiver filter and gain decode
    // ------------------------------------------------------------
    assign filter_select_low_subcarrier = rx_set_q[FILTER_LOW_BIT];
    assign filter_select_mid_subcarrier = rx_set_q[FILTER_MID_BIT];
    assign filter_select_manchester_subcarrier = rx_set_q[FILTER_MANCH_BIT];
    assign high_rate_filter = rx_set_q[HIGH_RATE_BIT];

    // total gain cut: wide filter adds 7 dB on top of the code
    always_comb begin
        logic [3:0] code_db;
        code_db = 4'h0;
        case (gain_red_e'(rx_set_q[GAIN_MSB:GAIN_LSB]))
            GAIN_0DB: code_db = 4'h0;
            GAIN_M5DB: code_db = 4'h5;
            GAIN_M10DB: code_db = 4'ha;
            GAIN_M15DB: code_db = 4'hf;
            default: code_db = 4'h0;
        endcase
        // saturate: 15 + 7 would not fit a nibble
        if (rx_set_q[HIGH_RATE_BIT]) begin
            gain_reduction_db = (code_db > 4'h8) ? 4'hf : code_db + 4'h7;
        end else begin
            gain_reduction_db = code_db;
        end
    end

    // ------------------------------------------------------------
    // regulator and I/O decode
    // ------------------------------------------------------------
    assign auto_regulator = reg_io_q[AUTO_REG_BIT];
    assign external_amplifier_support = reg_io_q[EXT_AMP_BIT];
    assign ook_pin_mod_output = reg_io_q[EXT_AMP_BIT];
    assign rx_external_subcarrier = reg_io_q[EXT_AMP_BIT];
    assign low_io_drive = reg_io_q[LOW_IO_BIT];
    assign voltage_code = reg_io_q[VCODE_MSB:0];

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // reload, write, decode and reserved-bit checks, one per guarded behaviour
    mod_reload_a: assert property (
        enable && proto_wr |=>
        mod_clk_q == ((MOD_CLK_RESET & ~CLK_DIV_FIELD) |
        ($past(mod_clk_q) & CLK_DIV_FIELD)))
        else $error("modulator register reload wrong");
    rx_reload_a: assert property (
        enable && proto_wr |=> rx_set_q == RX_SETTING_RESET)
        else $error("receiver register not reloaded");
    reg_keep_a: assert property (
        enable && proto_wr |=> reg_io_q == $past(reg_io_q))
        else $error("regulator register changed on protocol write");
    enable_low_a: assert property (
        !enable |=> mod_clk_q == MOD_CLK_RESET &&
        rx_set_q == RX_SETTING_RESET && reg_io_q == REGULATOR_RESET)
        else $error("enable low did not restore defaults");
    ext_sel_a: assert property (
        !(mod_clk_q[EXT_MOD_SEL_BIT] && direct_mode) |->
        ook_select == (modulation_depth == OOK_100))
        else $error("pin steered modulation outside direct mode");
    clk_dec_a: assert property (
        system_clock_output ==
        clk_out_e'({clock_divider_select_high, clock_divider_select_low}))
        else $error("clock output decode mismatch");
    // the top code must give the full carrier rate, not just any code
    clk_full_a: assert property (
        mod_clk_q[CLK_DIV_MSB:CLK_DIV_LSB] == 2'h3 |->
        system_clock_output == CLK_13M56)
        else $error("divider code 11 not full rate");
    gain_dec_a: assert property (
        !high_rate_filter && rx_set_q[GAIN_MSB:GAIN_LSB] == 2'h2 |->
        gain_reduction_db == 4'ha)
        else $error("gain code 10 not 10 dB");
    hbt_gain_a: assert property (
        high_rate_filter && rx_set_q[GAIN_MSB:GAIN_LSB] == 2'h0 |->
        gain_reduction_db == 4'h7)
        else $error("high rate gain cut not 7 dB");
    reserved_a: assert property (
        rx_set_q[1:0] == 2'h0 && mod_clk_q[7] == 1'b0 &&
        reg_io_q[4:3] == 2'h0)
        else $error("reserved bit set");
    wr_take_a: assert property (
        enable && !proto_wr && wr_en && wr_addr == ADDR_REGULATOR |=>
        reg_io_q == ($past(wr_data) & REGULATOR_MASK))
        else $error("regulator write not stored");

    proto_cov_c: cover property (enable && proto_wr);
    direct_pin_c: cover property (mod_clk_q[EXT_MOD_SEL_BIT] && direct_mode);
    hbt_cov_c: cover property (high_rate_filter);
    auto_off_c: cover property (!auto_regulator);
endmodule : cfg_regs

// *** design/cfg_regs_pkg.sv ***
// constants for the reader front end configuration register bank
package cfg_regs_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_PROTOCOL_CTRL = 5'h01;
    localparam logic [4:0] ADDR_MOD_CLK = 5'h09;
    localparam logic [4:0] ADDR_RX_SETTING = 5'h0a;
    localparam logic [4:0] ADDR_REGULATOR = 5'h0b;

    // ------------------------------------------------------------
    // reset values and writable bit masks
    // ------------------------------------------------------------
    localparam logic [7:0] MOD_CLK_RESET = 8'h11;
    localparam logic [7:0] RX_SETTING_RESET = 8'h40;
    localparam logic [7:0] REGULATOR_RESET = 8'h87;
    localparam logic [7:0] MOD_CLK_MASK = 8'h7f;
    localparam logic [7:0] RX_SETTING_MASK = 8'hfc;
    localparam logic [7:0] REGULATOR_MASK = 8'he7;
    localparam logic [7:0] CLK_DIV_FIELD = 8'h30;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int EXT_MOD_SEL_BIT = 6;
    localparam int CLK_DIV_MSB = 5;
    localparam int CLK_DIV_LSB = 4;
    localparam int ANALOG_OUT_BIT = 3;
    localparam int MOD_DEPTH_MSB = 2;
    localparam int FILTER_LOW_BIT = 7;
    localparam int FILTER_MID_BIT = 6;
    localparam int FILTER_MANCH_BIT = 5;
    localparam int HIGH_RATE_BIT = 4;
    localparam int GAIN_MSB = 3;
    localparam int GAIN_LSB = 2;
    localparam int AUTO_REG_BIT = 7;
    localparam int EXT_AMP_BIT = 6;
    localparam int LOW_IO_BIT = 5;
    localparam int VCODE_MSB = 2;

    // ------------------------------------------------------------
    // decoded enumerations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CLK_OFF, CLK_3M3, CLK_6M78, CLK_13M56
    } clk_out_e;
    typedef enum logic [2:0] {
        ASK_10, OOK_100, ASK_7, ASK_8P5, ASK_13, ASK_16, ASK_22, ASK_30
    } mod_depth_e;
    typedef enum logic [1:0] {
        GAIN_0DB, GAIN_M5DB, GAIN_M10DB, GAIN_M15DB
    } gain_red_e;
endpackage : cfg_regs_pkg

// *** design/cfg_byte_reg.sv ***
// one byte-wide configuration register with reload and write masks
`timescale 1ns/1ps
module cfg_byte_reg
    import cfg_regs_pkg::*;
#(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] WR_MASK = 8'hff,
    parameter logic [7:0] RELOAD_MASK = 8'h00
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic enable,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    input wire logic reload,
    output logic [7:0] value_q
);
    logic [7:0] value_d;

    // reload only touches bits in RELOAD_MASK; others keep their value
    always_comb begin
        value_d = value_q;
        if (!enable) begin
            value_d = RESET_VAL;
        end else if (reload) begin
            value_d = (value_q & ~RELOAD_MASK) | (RESET_VAL & RELOAD_MASK);
        end else if (wr_en) begin
            value_d = wr_data & WR_MASK; // unused bits stay zero
        end
    end

    // storage, power-on reset loads the default
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            value_q <= RESET_VAL;
        end else begin
            value_q <= value_d;
        end
    end
endmodule : cfg_byte_reg

// *** tb/host_model.sv ***
// host side model that issues byte writes to the register bank
`timescale 1ns/1ps
module host_model #(
    parameter int IO_MV = 3300
) (
    input wire logic mclk,
    output logic wr_en,
    output logic [4:0] wr_addr,
    output logic [7:0] wr_data
);
    // ------------------------------------------------------------
    // bus lines idle low before the first write
    // ------------------------------------------------------------
    initial begin
        wr_en = 1'b0;
        wr_addr = 5'h00;
        wr_data = 8'h00;
    end

    // one-cycle strobe; released lines show the inverse, so stale data
    // can never pass for a fresh write
    task automatic write(input logic [4:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr_en <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        @(posedge mclk);
        wr_en <= 1'b0;
        wr_addr <= ~a;
        wr_data <= ~d;
    endtask : write

    // low i/o supply forces the low-voltage drive bit on
    function automatic logic [7:0] io_fix(input logic [7:0] d);
        return (IO_MV < 2700) ? (d | 8'h20) : d;
    endfunction : io_fix
endmodule : host_model

// *** tb/cfg_regs_test.sv ***
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
    err_count++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module cfg_regs_test;
    import cfg_regs_pkg::*;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic enable = 1'b1;
    logic direct_mode = 1'b0;
    logic ask_ook_pin = 1'b0;
    logic [4:0] rd_addr = 5'h00;
    logic wr_en;
    logic [4:0] wr_addr;
    logic [7:0] wr_data, rd_data, em, er, eg, d;
    logic ook_select, analog_test_out, cdh, cdl, fl, fm, fh, hr;
    logic auto_regulator, eas, ook_mod, rx_ext, low_io_drive;
    clk_out_e system_clock_output;
    mod_depth_e modulation_depth;
    logic [3:0] gain_reduction_db;
    logic [2:0] voltage_code;
    int err_count = 0;
    int total_checks = 0;
    int seed = 32'he0da;
    host_model host (.mclk(mclk), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data));
    cfg_regs dut (.mclk(mclk), .reset_n(reset_n), .enable(enable),
        .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_addr(rd_addr), .rd_data(rd_data), .direct_mode(direct_mode),
        .ask_ook_pin(ask_ook_pin), .ook_select(ook_select),
        .analog_test_out(analog_test_out),
        .clock_divider_select_high(cdh), .clock_divider_select_low(cdl),
        .system_clock_output(system_clock_output),
        .modulation_depth(modulation_depth),
        .filter_select_low_subcarrier(fl), .filter_select_mid_subcarrier(fm),
        .filter_select_manchester_subcarrier(fh), .high_rate_filter(hr),
        .gain_reduction_db(gain_reduction_db),
        .auto_regulator(auto_regulator), .external_amplifier_support(eas),
        .ook_pin_mod_output(ook_mod), .rx_external_subcarrier(rx_ext),
        .low_io_drive(low_io_drive), .voltage_code(voltage_code));
    // 100 ns period
    initial begin
        forever #50 mclk = ~mclk;
    end
    // ------------------------------------------------------------
    // expectation helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] exp_gain(input logic [7:0] r);
        int s;
        s = r[3:2] * 5 + (r[4] ? 7 : 0);
        return (s > 15) ? 4'hf : 4'(s);
    endfunction : exp_gain
    task automatic chk_rd(input logic [4:0] a, input logic [7:0] e);
        @(posedge mclk);
        rd_addr <= a;
        @(negedge mclk);
        `CHK(rd_data, e)
    endtask : chk_rd
    // register contents first, then every decoded field
    task automatic chk_all();
        chk_rd(ADDR_MOD_CLK, em);
        chk_rd(ADDR_RX_SETTING, er);
        chk_rd(ADDR_REGULATOR, eg);
        `CHK({cdh, cdl}, em[5:4])
        `CHK(system_clock_output, clk_out_e'(em[5:4]))
        `CHK(analog_test_out, em[3])
        `CHK(modulation_depth, mod_depth_e'(em[2:0]))
        `CHK({fl, fm, fh}, er[7:5])
        `CHK(hr, er[4])
        `CHK(gain_reduction_db, exp_gain(er))
        `CHK(auto_regulator, eg[7])
        `CHK({eas, ook_mod, rx_ext}, {3{eg[6]}})
        `CHK(low_io_drive, eg[5])
        `CHK(voltage_code, eg[2:0])
    endtask : chk_all
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results
    // hang guard
    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        results();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        em = MOD_CLK_RESET;
        er = RX_SETTING_RESET;
        eg = REGULATOR_RESET;
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        chk_all();
        chk_rd(5'h1f, 8'h00);
        $display("test reset values done");
        // random writes with corner bytes, protocol writes among them
        for (int i = 0; i < 45; i++) begin
            d = (i < 3) ? 8'hff : 8'($random(seed));
            if (i % 8 == 7) begin
                host.write(ADDR_PROTOCOL_CTRL, d);
                em = (MOD_CLK_RESET & ~CLK_DIV_FIELD) | (em & CLK_DIV_FIELD);
                er = RX_SETTING_RESET;
            end else if (i % 3 == 0) begin
                host.write(ADDR_MOD_CLK, d);
                em = d & MOD_CLK_MASK;
            end else if (i % 3 == 1) begin
                host.write(ADDR_RX_SETTING, d);
                er = d & RX_SETTING_MASK;
            end else begin
                host.write(ADDR_REGULATOR, host.io_fix(d));
                eg = host.io_fix(d) & REGULATOR_MASK;
            end
            chk_all();
        end
        $display("test random writes done");
        // gain corners: wide filter alone, then code 10 alone
        host.write(ADDR_RX_SETTING, 8'h10);
        er = 8'h10;
        chk_all();
        host.write(ADDR_RX_SETTING, 8'h08);
        er = 8'h08;
        chk_all();
        // mid-run power-on reset brings every default back
        @(posedge mclk);
        reset_n <= 1'b0;
        @(posedge mclk);
        reset_n <= 1'b1;
        em = MOD_CLK_RESET;
        er = RX_SETTING_RESET;
        eg = REGULATOR_RESET;
        chk_all();
        $display("test gain corners and reset done");
        // enable low reloads all three and drops writes
        @(posedge mclk);
        enable <= 1'b0;
        host.write(ADDR_REGULATOR, 8'h00);
        enable <= 1'b1;
        em = MOD_CLK_RESET;
        er = RX_SETTING_RESET;
        eg = REGULATOR_RESET;
        chk_all();
        $display("test enable low done");
        // external ook choice only in direct mode
        host.write(ADDR_MOD_CLK, 8'h42);
        direct_mode <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            @(posedge mclk);
            ask_ook_pin <= k[0];
            if (k == 3) begin
                direct_mode <= 1'b0;
            end
            repeat (6) @(negedge mclk);
            `CHK(ook_select, (k < 3) & k[0])
        end
        host.write(ADDR_MOD_CLK, 8'h41);
        repeat (2) @(negedge mclk);
        `CHK(ook_select, 1'b1)
        $display("test external ook done");
        results();
    end
endmodule : cfg_regs_test
